// file: rtl/uden_top.sv
// UART data ports, interrupt enables, flow control and a small serial core.
// Assumes AHB-Lite master, asynchronous RXD/CTS pins, CTS and RTS active low.
`timescale 1ns/1ps
module uden_top
    import uden_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic RXD,
    output logic TXD,
    input wire logic CTS_N,
    output logic RTS_N,
    input wire logic POWER_DOWN,
    output logic WAKE_REQ,
    output logic IRQ
);
    logic rst_a, rst_b;
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_a <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_b <= rst_a;
        end
    end
    wire rst_n = rst_b;

    // Pin synchronisers; first stage feeds only the second
    logic [2:0] sy1, sy2;
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sy1 <= 3'b111;
            sy2 <= 3'b111;
        end else begin
            sy1 <= {POWER_DOWN, CTS_N, RXD};
            sy2 <= sy1;
        end
    end
    wire rx_s = sy2[0];
    wire cts_n_s = sy2[1];
    wire pd_s = sy2[2];

    // Bus address phase capture
    logic dp_wr, dp_rd;
    logic [11:0] dp_addr;
    wire ap = HSEL && HREADY && HTRANS[1];
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= ADDR_DATA;
        end else begin
            dp_wr <= ap && HWRITE;
            dp_rd <= ap && !HWRITE;
            dp_addr <= HADDR[11:0];
        end
    end
    logic [31:0] ien, cfg;
    logic [5:0] stat;
    wire wr_ien = dp_wr && dp_addr == ADDR_IEN;
    wire wr_cfg = dp_wr && dp_addr == ADDR_CFG;
    wire wr_stat = dp_wr && dp_addr == ADDR_STAT;
    wire wr_tx = dp_wr && dp_addr == ADDR_DATA;
    wire rd_rx_ap = ap && !HWRITE && HADDR[11:0] == ADDR_DATA;

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n)
            ien <= IEN_RESET;
        else if (wr_ien)
            ien <= HWDATA & IEN_MASK;
    end
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n)
            cfg <= IEN_RESET;
        else if (wr_cfg)
            cfg <= HWDATA & CFG_MASK;
    end
    wire [4:0] rx_lev = uden_level(cfg[CFG_RXLEV_LO +: 4]);
    wire [4:0] rts_lev = uden_level(cfg[CFG_RTSLEV_LO +: 4]);

    // Baud tick
    logic [10:0] bdiv;
    logic tick;
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bdiv <= 11'h000;
            tick <= 1'b0;
        end else begin
            tick <= bdiv == 11'(BAUD_DIV - 1);
            bdiv <= (bdiv == 11'(BAUD_DIV - 1)) ? 11'h000 : bdiv + 11'h001;
        end
    end

    // Transmit holding byte, one deep
    logic [7:0] tx_data_byte;
    logic thr_full;
    uden_state_t tx_st;
    logic [3:0] tx_cnt;
    logic [7:0] tx_sh;
    wire tx_go = thr_full && tick && tx_st == UDEN_IDLE && !(ien[IEN_ACTS] && cts_n_s);
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_byte <= 8'h00;
            thr_full <= 1'b0;
        end else if (wr_tx) begin
            tx_data_byte <= HWDATA[7:0];
            thr_full <= 1'b1;
        end else if (tx_go)
            thr_full <= 1'b0;
    end
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_st <= UDEN_IDLE;
            tx_cnt <= 4'h0;
            tx_sh <= 8'h00;
            TXD <= 1'b1;
        end else if (tick) begin
            case (tx_st)
                UDEN_IDLE: begin
                    TXD <= 1'b1;
                    if (tx_go) begin
                        tx_sh <= tx_data_byte;
                        TXD <= 1'b0;
                        tx_cnt <= 4'h0;
                        tx_st <= UDEN_DATA;
                    end
                end
                UDEN_DATA: begin
                    TXD <= tx_sh[0];
                    tx_sh <= {1'b0, tx_sh[7:1]};
                    tx_cnt <= tx_cnt + 4'h1;
                    if (tx_cnt == 4'h7)
                        tx_st <= UDEN_STOP;
                end
                UDEN_STOP: begin
                    TXD <= 1'b1;
                    tx_st <= UDEN_IDLE;
                end
                default: tx_st <= UDEN_IDLE;
            endcase
        end
    end

    // Receiver samples mid-bit using a half-period offset counter
    uden_state_t rx_st;
    logic [10:0] rx_div;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sh;
    logic rx_done, rx_ferr;
    wire rx_mid = rx_div == 11'(BAUD_DIV - 1);
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_st <= UDEN_IDLE;
            rx_div <= 11'h000;
            rx_cnt <= 4'h0;
            rx_sh <= 8'h00;
            rx_done <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            rx_ferr <= 1'b0;
            rx_div <= rx_mid ? 11'h000 : rx_div + 11'h001;
            case (rx_st)
                UDEN_IDLE: if (!rx_s) begin
                    rx_div <= 11'(BAUD_DIV / 2);
                    rx_st <= UDEN_START;
                end
                UDEN_START: if (rx_mid) begin
                    rx_cnt <= 4'h0;
                    rx_st <= rx_s ? UDEN_IDLE : UDEN_DATA;
                end
                UDEN_DATA: if (rx_mid) begin
                    rx_sh <= {rx_s, rx_sh[7:1]};
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == 4'h7)
                        rx_st <= UDEN_STOP;
                end
                UDEN_STOP: if (rx_mid) begin
                    rx_done <= rx_s;
                    rx_ferr <= !rx_s;
                    rx_st <= UDEN_IDLE;
                end
                default: rx_st <= UDEN_IDLE;
            endcase
        end
    end

    // Receive FIFO in flip-flops
    logic [7:0] rx_mem [FIFO_DEPTH];
    logic [3:0] rx_wp, rx_rp;
    logic [4:0] rx_count;
    wire rx_full = rx_count == FIFO_FULL;
    wire rx_push = rx_done && !rx_full;
    wire rx_pop = rd_rx_ap && rx_count != 5'h00;
    always_ff @(posedge REF_CLK) begin
        if (rx_push)
            rx_mem[rx_wp] <= rx_sh;
    end
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_count <= 5'h00;
        end else begin
            if (rx_push)
                rx_wp <= rx_wp + 4'h1;
            if (rx_pop)
                rx_rp <= rx_rp + 4'h1;
            rx_count <= rx_count + 5'(rx_push) - 5'(rx_pop);
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n)
            RTS_N <= 1'b1;
        else
            RTS_N <= ien[IEN_ARTS] ? (rx_count >= rts_lev) : 1'b0;
    end

    logic [15:0] rto_cnt;
    logic rto_hit;
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rto_cnt <= 16'h0000;
            rto_hit <= 1'b0;
        end else begin
            rto_hit <= 1'b0;
            if (!ien[IEN_TOUT] || rx_push || rx_pop || rx_count == 5'h00)
                rto_cnt <= 16'h0000;
            else if (tick && rto_cnt != 16'(RTO_CHARS * 10)) begin
                rto_cnt <= rto_cnt + 16'h0001;
                rto_hit <= rto_cnt == 16'(RTO_CHARS * 10 - 1);
            end
        end
    end

    logic cts_d;
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cts_d <= 1'b1;
            WAKE_REQ <= 1'b0;
        end else begin
            cts_d <= cts_n_s;
            WAKE_REQ <= ien[IEN_WAKE] && pd_s && (cts_d != cts_n_s);
        end
    end

    // Sticky status, write one to clear, set wins
    uden_flags_t ev;
    always_comb begin
        ev.buf_err = rx_done && rx_full;
        ev.rx_timeout = rto_hit;
        ev.modem = cts_d != cts_n_s;
        ev.line_status = rx_ferr;
        ev.tx_empty = wr_tx ? 1'b0 : !thr_full;
        ev.rx_available = rx_push && (rx_count + 5'h01 == rx_lev);
    end
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n)
            stat <= 6'h00;
        else
            stat <= (stat & ~(wr_stat ? HWDATA[5:0] : 6'h00)) | ev;
    end

    wire [5:0] gated = stat & ien[IEN_BUF:IEN_RDA];
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n)
            IRQ <= 1'b0;
        else
            // Masks the next sticky value, so the level follows the flags with no extra lag
            IRQ <= |(((stat & ~(wr_stat ? HWDATA[5:0] : 6'h00)) | ev) & ien[IEN_BUF:IEN_RDA]);
    end

    // Read data, registered: one-cycle zero-wait answer
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n)
            HRDATA <= 32'h0000_0000;
        else if (ap && !HWRITE) begin
            case (HADDR[11:0])
                ADDR_DATA: HRDATA <= {24'h00_0000, rx_mem[rx_rp]};
                ADDR_IEN: HRDATA <= ien;
                ADDR_CFG: HRDATA <= cfg;
                ADDR_STAT: HRDATA <= {11'h000, rx_count, 10'h000, stat};
                default: HRDATA <= 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge REF_CLK or negedge rst_n) begin
        if (!rst_n) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    property p_ien_reset;
        @(posedge REF_CLK) $rose(rst_n) |-> ien == IEN_RESET;
    endproperty
    a_ien_reset: assert property (p_ien_reset)
        else $error("enable register not zero after reset");
    property p_thre;
        @(posedge REF_CLK) disable iff (!rst_n) (ien[IEN_THRE] && ev.tx_empty) |=> IRQ;
    endproperty
    a_thre: assert property (p_thre) else $error("tx empty irq not raised");
    property p_cts_block;
        @(posedge REF_CLK) disable iff (!rst_n)
            (tx_st == UDEN_IDLE && ien[IEN_ACTS] && cts_n_s) |=> tx_st == UDEN_IDLE;
    endproperty
    a_cts_block: assert property (p_cts_block) else $error("tx started with CTS high");
    property p_rts;
        @(posedge REF_CLK) disable iff (!rst_n)
            (ien[IEN_ARTS] && rx_count >= rts_lev) |=> RTS_N;
    endproperty
    a_rts: assert property (p_rts) else $error("RTS not dropped at level");
    property p_tout;
        @(posedge REF_CLK) disable iff (!rst_n) !ien[IEN_TOUT] |=> rto_cnt == 16'h0000;
    endproperty
    a_tout: assert property (p_tout) else $error("time-out counts while disabled");
    property p_wake;
        @(posedge REF_CLK) disable iff (!rst_n) WAKE_REQ |-> $past(ien[IEN_WAKE]) && $past(pd_s);
    endproperty
    a_wake: assert property (p_wake) else $error("wake without enable");
    property p_irq;
        @(posedge REF_CLK) disable iff (!rst_n) IRQ |-> $past(|(stat | ev)) || |gated;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt with nothing pending");
    property p_mask;
        @(posedge REF_CLK) disable iff (!rst_n) (|gated) |-> IRQ || $past(wr_stat) || $past(wr_ien);
    endproperty
    a_mask: assert property (p_mask) else $error("enabled flag did not raise irq");
    property p_rda;
        @(posedge REF_CLK) disable iff (!rst_n) ev.rx_available |=> stat[0];
    endproperty
    a_rda: assert property (p_rda) else $error("rx available flag lost");
    property p_pop;
        @(posedge REF_CLK) disable iff (!rst_n) (rx_pop && !rx_push) |=> rx_count == $past(rx_count) - 5'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not pop");
    property p_thr;
        @(posedge REF_CLK) disable iff (!rst_n) wr_tx |=> thr_full && tx_data_byte == $past(HWDATA[7:0]);
    endproperty
    a_thr: assert property (p_thr) else $error("tx byte not queued");
    c_tx: cover property (@(posedge REF_CLK) tx_st == UDEN_STOP);
    c_rx: cover property (@(posedge REF_CLK) rx_push);
    c_irq: cover property (@(posedge REF_CLK) $rose(IRQ));
endmodule : uden_top

// file: inc/uden_pkg.sv
// Constants, register map and carrier types of the UART data and enable block.
// Assumes one 200 MHz clock and an AHB-Lite slave port.
package uden_pkg;
    localparam logic [11:0] ADDR_DATA = 12'h000;
    localparam logic [11:0] ADDR_IEN = 12'h004;
    localparam logic [11:0] ADDR_CFG = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00C;
    localparam logic [31:0] IEN_RESET = 32'h0000_0000;
    localparam logic [31:0] IEN_MASK = 32'h0000_387F;
    localparam logic [31:0] CFG_MASK = 32'h000F_00F0;
    localparam int IEN_RDA = 0;
    localparam int IEN_THRE = 1;
    localparam int IEN_RLS = 2;
    localparam int IEN_MODEM = 3;
    localparam int IEN_RTO = 4;
    localparam int IEN_BUF = 5;
    localparam int IEN_WAKE = 6;
    localparam int IEN_TOUT = 11;
    localparam int IEN_ARTS = 12;
    localparam int IEN_ACTS = 13;
    localparam int CFG_RXLEV_LO = 4;
    localparam int CFG_RTSLEV_LO = 16;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_FULL = 5'h10;
    localparam int BAUD_DIV = 1736;
    localparam int RTO_CHARS = 4;
    localparam int BIT_CNT_TOP = 9;
    typedef enum logic [1:0] {UDEN_IDLE, UDEN_START, UDEN_DATA, UDEN_STOP} uden_state_t;
    typedef struct packed {
        logic buf_err;
        logic rx_timeout;
        logic modem;
        logic line_status;
        logic tx_empty;
        logic rx_available;
    } uden_flags_t;
    function automatic logic [4:0] uden_level(input logic [3:0] code);
        case (code)
            4'h0: uden_level = 5'h01;
            4'h1: uden_level = 5'h04;
            4'h2: uden_level = 5'h08;
            4'h3: uden_level = 5'h0E;
            default: uden_level = 5'h01;
        endcase
    endfunction : uden_level
endpackage : uden_pkg

// file: sim/uden_serial_dev.sv
// Serial device model on the far side of the UART pins.
// Assumes 8N1 framing at 1736 clock cycles per bit and an idle-high line.
`timescale 1ns/1ps
module uden_serial_dev (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    localparam int BIT_CLKS = 1736;
    logic [7:0] got[$];
    logic [7:0] v;
    initial rxd = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        rxd <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk);
    endtask : send_byte
    always begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            v[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge clk);
        got.push_back(v);
    end
endmodule : uden_serial_dev

// file: sim/test_uart_data_and_irq_enable.sv
// Self-checking bench for the UART data and enable block.
// Assumes the serial device model drives RXD and watches TXD.
`timescale 1ns/1ps
module test_uart_data_and_irq_enable;
    import uden_pkg::*;
    logic REF_CLK = 1'b0;
    logic NRST = 1'b0;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0000_0000;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0000_0000;
    logic CTS_N = 1'b1;
    logic POWER_DOWN = 1'b0;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, RXD, TXD, RTS_N, WAKE_REQ, IRQ;
    int fail_count = 0;
    int n_checks = 0;
    int seed = 32'hcd06;
    int k;
    logic [31:0] ien_model = 32'h0000_0000;
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic [31:0] rd;
    logic [7:0] b;

    always #2.5 REF_CLK = ~REF_CLK;

    uden_top i_dut (.REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .RXD(RXD), .TXD(TXD), .CTS_N(CTS_N), .RTS_N(RTS_N), .POWER_DOWN(POWER_DOWN),
        .WAKE_REQ(WAKE_REQ), .IRQ(IRQ));
    uden_serial_dev i_dev (.clk(REF_CLK), .txd(TXD), .rxd(RXD));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 100);
        if (HREADYOUT !== 1'b1) begin
            fail_count++;
            print_verdict();
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {20'h0_0000, a};
        HWRITE <= wr;
        wait_ready();
        HTRANS <= 2'h0;
        HWDATA <= wd;
        wait_ready();
        rd = HRDATA;
    endtask : bus

    task automatic ien_wr(input logic [31:0] v);
        bus(1'b1, ADDR_IEN, v);
        ien_model = v & IEN_MASK;
    endtask : ien_wr

    task automatic count_wake();
        k = 0;
        repeat (10) begin
            @(posedge REF_CLK);
            if (WAKE_REQ === 1'b1) k++;
        end
    endtask : count_wake

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #400_000;
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge REF_CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        check(TXD, 1);
        check(IRQ, 0);
        bus(1'b0, ADDR_IEN, 32'h0);
        check(rd, IEN_RESET);
        check(HRESP, 0);
        ien_wr($random(seed));
        bus(1'b0, ADDR_IEN, 32'h0);
        check(rd, ien_model);
        bus(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0000_0000);
        // Transmit held back while clear-to-send is deasserted
        ien_wr(32'h0000_2000);
        bus(1'b1, ADDR_CFG, 32'h0);
        b = $random(seed);
        tx_q.push_back(b);
        bus(1'b1, ADDR_DATA, {24'h00_0000, b});
        k = 0;
        repeat (4000) begin
            @(posedge REF_CLK);
            if (TXD !== 1'b1) k++;
        end
        check(k, 0);
        CTS_N <= 1'b0;
        k = 0;
        while (i_dev.got.size() == 0 && k < 25000) begin
            @(posedge REF_CLK);
            k++;
        end
        check(i_dev.got.size(), 1);
        if (i_dev.got.size() > 0) check(i_dev.got.pop_front(), tx_q.pop_front());
        // Receive one byte with trigger levels of one byte
        ien_wr(32'h0000_1001);
        bus(1'b1, ADDR_STAT, 32'h0000_003F);
        b = $random(seed);
        rx_q.push_back(b);
        i_dev.send_byte(b);
        repeat (20) @(posedge REF_CLK);
        check(IRQ, ien_model[IEN_RDA]);
        check(RTS_N, 1);
        bus(1'b0, ADDR_STAT, 32'h0);
        check(rd & 32'h001F_0001, 32'h0001_0001);
        ien_wr(32'h0000_1000);
        repeat (3) @(posedge REF_CLK);
        check(IRQ, ien_model[IEN_RDA]);
        bus(1'b0, ADDR_DATA, 32'h0);
        check(rd[7:0], rx_q.pop_front());
        repeat (3) @(posedge REF_CLK);
        check(RTS_N, 0);
        // Clear-to-send change during power-down
        ien_wr(32'h0000_0048);
        bus(1'b1, ADDR_STAT, 32'h0000_003F);
        POWER_DOWN <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        CTS_N <= 1'b1;
        count_wake();
        check(k, 1);
        check(IRQ, ien_model[IEN_MODEM]);
        bus(1'b1, ADDR_STAT, 32'h0000_0008);
        repeat (3) @(posedge REF_CLK);
        check(IRQ, 0);
        ien_wr(32'h0000_0000);
        CTS_N <= 1'b0;
        count_wake();
        check(k, 0);
        check(IRQ, ien_model[IEN_MODEM]);
        // Holding byte is empty, so only the transmit-empty enable is needed
        ien_wr(32'h0000_0002);
        repeat (3) @(posedge REF_CLK);
        check(IRQ, 1);
        print_verdict();
    end
endmodule : test_uart_data_and_irq_enable
